// *** verilog/dac_serial_dev.sv ***
// DAC serial input port, clocked only by the link clock.
`timescale 1ns/10ps
`default_nettype none
module dac_serial_dev
  import dac_link_pkg::*;
(
  // Link
  dac_link_if.dev link,
  // Reset, synchronous to the link clock
  input wire logic i_reset,
  // DAC register and edge setting
  output logic [CODE_W-1:0] o_dac_code,
  output logic o_rise_edge
);

  // ****************************************************************
  // State
  // ****************************************************************
  // Each edge of the link clock owns one capture bank. The bank that
  // latched last owns the DAC state; toggles show which one that is,
  // so no register is ever written from both edges.
  word_t fshift_reg, fshift_next;
  logic fhold_reg, fhold_next;
  code_t fcode_reg, fcode_next;
  logic fmode_reg, fmode_next;
  logic ftog_reg, ftog_next;
  bit_count_t fcount_reg, fcount_next;
  logic nout_reg, nout_next;

  word_t rshift_reg, rshift_next;
  logic rhold_reg, rhold_next;
  code_t rcode_reg, rcode_next;
  logic rmode_reg, rmode_next;
  logic rtog_reg, rtog_next;
  bit_count_t rcount_reg, rcount_next;
  logic pout_reg, pout_next;

  logic owner_rise;
  code_t cur_code;
  logic cur_mode;
  word_t fword;
  word_t rword;
  word_t cur_shift;
  word_t fbase;
  word_t rbase;
  logic fall_act;
  logic rise_act;

  assign owner_rise = ftog_reg ^ rtog_reg;
  assign cur_code = owner_rise ? rcode_reg : fcode_reg;
  assign cur_mode = owner_rise ? rmode_reg : fmode_reg;
  // A bank that has seen an edge keeps the link to the end of the frame,
  // so an edge command latched on the sixteenth edge waits for the next frame.
  assign fall_act = (fcount_reg != 5'h00) || (rcount_reg == 5'h00 && !cur_mode);
  assign rise_act = (rcount_reg != 5'h00) || (fcount_reg == 5'h00 && cur_mode);
  // The first edge of a frame continues from the word of the bank that latched
  // last. A short frame after an edge change is therefore not carried over.
  assign cur_shift = owner_rise ? rshift_reg : fshift_reg;
  assign fbase = (fcount_reg == 5'h00) ? cur_shift : fshift_reg;
  assign rbase = (rcount_reg == 5'h00) ? cur_shift : rshift_reg;
  assign fword = {fbase[WORD_W-2:0], link.serial_in};
  assign rword = {rbase[WORD_W-2:0], link.serial_in};

  assign o_dac_code = cur_code;
  assign o_rise_edge = cur_mode;
  // Chained output leaves on the edge opposite the capture edge.
  assign link.serial_out = rise_act ? nout_reg : pout_reg;

  // ****************************************************************
  // Falling-edge bank
  // ****************************************************************
  always_comb
  begin
    fshift_next = fshift_reg;
    fhold_next = fhold_reg;
    fcode_next = fcode_reg;
    fmode_next = fmode_reg;
    ftog_next = ftog_reg;
    fcount_next = fcount_reg;
    nout_next = nout_reg;
    if (!link.frame_n && fall_act)
    begin
      fhold_next = fbase[WORD_W-1];
      fshift_next = fword;
      if (fcount_reg != BIT_DONE)
      begin
        fcount_next = fcount_reg + 5'h01;
      end
      if (fcount_reg == BIT_LAST)
      begin
        ftog_next = rtog_reg;
        fcode_next = cur_code;
        fmode_next = cur_mode;
        case (cmd_of(fword))
          CMD_LOAD:
          begin
            fcode_next = code_of(fword);
          end
          CMD_EDGE_RISE:
          begin
            fmode_next = 1'b1;
          end
          CMD_EDGE_FALL:
          begin
            fmode_next = 1'b0;
          end
          CMD_READBACK:
          begin
            fshift_next = readback_word(cur_code);
          end
          default:
          begin
            fcode_next = cur_code;
          end
        endcase
      end
    end
    if (!link.frame_n && rise_act)
    begin
      nout_next = rhold_reg;
    end
  end

  always_ff @(negedge link.ser_clk)
  begin
    if (i_reset)
    begin
      fshift_reg <= '0;
      fhold_reg <= 1'b0;
      fcode_reg <= CODE_RESET;
      fmode_reg <= MODE_RESET_RISE;
      ftog_reg <= 1'b0;
      nout_reg <= 1'b0;
    end
    else
    begin
      fshift_reg <= fshift_next;
      fhold_reg <= fhold_next;
      fcode_reg <= fcode_next;
      fmode_reg <= fmode_next;
      ftog_reg <= ftog_next;
      nout_reg <= nout_next;
    end
  end

  // The link clock stops between frames, so the frame signal itself
  // clears the edge count.
  always_ff @(negedge link.ser_clk or posedge link.frame_n)
  begin
    if (link.frame_n)
    begin
      fcount_reg <= '0;
    end
    else if (i_reset)
    begin
      fcount_reg <= '0;
    end
    else
    begin
      fcount_reg <= fcount_next;
    end
  end

  // ****************************************************************
  // Rising-edge bank
  // ****************************************************************
  always_comb
  begin
    rshift_next = rshift_reg;
    rhold_next = rhold_reg;
    rcode_next = rcode_reg;
    rmode_next = rmode_reg;
    rtog_next = rtog_reg;
    rcount_next = rcount_reg;
    pout_next = pout_reg;
    if (!link.frame_n && rise_act)
    begin
      rhold_next = rbase[WORD_W-1];
      rshift_next = rword;
      if (rcount_reg != BIT_DONE)
      begin
        rcount_next = rcount_reg + 5'h01;
      end
      if (rcount_reg == BIT_LAST)
      begin
        rtog_next = ~ftog_reg;
        rcode_next = cur_code;
        rmode_next = cur_mode;
        case (cmd_of(rword))
          CMD_LOAD:
          begin
            rcode_next = code_of(rword);
          end
          CMD_EDGE_RISE:
          begin
            rmode_next = 1'b1;
          end
          CMD_EDGE_FALL:
          begin
            rmode_next = 1'b0;
          end
          CMD_READBACK:
          begin
            rshift_next = readback_word(cur_code);
          end
          default:
          begin
            rcode_next = cur_code;
          end
        endcase
      end
    end
    if (!link.frame_n && fall_act)
    begin
      pout_next = fhold_reg;
    end
  end

  always_ff @(posedge link.ser_clk)
  begin
    if (i_reset)
    begin
      rshift_reg <= '0;
      rhold_reg <= 1'b0;
      rcode_reg <= CODE_RESET;
      rmode_reg <= MODE_RESET_RISE;
      rtog_reg <= 1'b0;
      pout_reg <= 1'b0;
    end
    else
    begin
      rshift_reg <= rshift_next;
      rhold_reg <= rhold_next;
      rcode_reg <= rcode_next;
      rmode_reg <= rmode_next;
      rtog_reg <= rtog_next;
      pout_reg <= pout_next;
    end
  end

  always_ff @(posedge link.ser_clk or posedge link.frame_n)
  begin
    if (link.frame_n)
    begin
      rcount_reg <= '0;
    end
    else if (i_reset)
    begin
      rcount_reg <= '0;
    end
    else
    begin
      rcount_reg <= rcount_next;
    end
  end

endmodule // dac_serial_dev
`default_nettype wire

// *** verilog/dac_link_pkg.sv ***
// Shared constants, types and helpers for the serial DAC link.
package dac_link_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int WORD_W = 16;
  localparam int CMD_W = 4;
  localparam int CODE_W = 12;
  localparam int CMD_LSB = 12;
  localparam int CODE_LSB = 0;

  typedef logic [WORD_W-1:0] word_t;
  typedef logic [CMD_W-1:0] cmd_t;
  typedef logic [CODE_W-1:0] code_t;
  typedef logic [4:0] bit_count_t;

  localparam cmd_t CMD_NOP = 4'h0;
  localparam cmd_t CMD_LOAD = 4'h1;
  localparam cmd_t CMD_READBACK = 4'h2;
  localparam cmd_t CMD_EDGE_RISE = 4'h9;
  localparam cmd_t CMD_EDGE_FALL = 4'hA;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam code_t CODE_RESET = 12'h000;
  localparam logic MODE_RESET_RISE = 1'b0;
  localparam bit_count_t BIT_LAST = 5'h0F;
  localparam bit_count_t BIT_DONE = 5'h10;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SCLK_MAX_MHZ = 50;
  localparam int SCLK_MIN_PERIOD_NS = 1000 / SCLK_MAX_MHZ;
  localparam int SCLK_HALF_MIN_CYC = (SCLK_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Chained and readback transfers must run well below the top rate.
  localparam int SCLK_SLOWDOWN = 8;
  localparam int SCLK_HALF_CYC = SCLK_HALF_MIN_CYC * SCLK_SLOWDOWN;
  localparam int FRAME_GAP_NS = 30;
  localparam int FRAME_GAP_CYC = (FRAME_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  function automatic cmd_t cmd_of(input word_t w);
    cmd_of = w[CMD_LSB +: CMD_W];
  endfunction

  function automatic code_t code_of(input word_t w);
    code_of = w[CODE_LSB +: CODE_W];
  endfunction

  function automatic word_t readback_word(input code_t c);
    readback_word = {CMD_READBACK, c};
  endfunction

endpackage

// *** verilog/dac_link_if.sv ***
// Interface carrying the four serial link wires between host and DAC.
`timescale 1ns/10ps
`default_nettype none
interface dac_link_if;
  logic ser_clk;
  logic frame_n;
  logic serial_in;
  logic serial_out;

  modport host
  (
    output ser_clk,
    output frame_n,
    output serial_in,
    input serial_out
  );

  modport dev
  (
    input ser_clk,
    input frame_n,
    input serial_in,
    output serial_out
  );
endinterface
`default_nettype wire

// *** verilog/dac_serial_host.sv ***
// Host end of the serial DAC link: makes the link clock and frames words.
`timescale 1ns/10ps
`default_nettype none
module dac_serial_host
  import dac_link_pkg::*;
(
  // System
  input wire logic i_clk,
  input wire logic i_reset,
  // Link
  dac_link_if.host link,
  // User request
  input wire logic i_start,
  input wire logic [WORD_W-1:0] i_word,
  // User answer
  output logic o_busy,
  output logic o_done,
  output logic [WORD_W-1:0] o_rx_word,
  output logic o_rise_edge
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum {ST_IDLE, ST_LEAD, ST_ACTIVE, ST_GAP} state_t;
  typedef logic [3:0] timer_t;

  localparam timer_t HALF_LOAD = 4'(SCLK_HALF_CYC - 1);
  localparam timer_t GAP_LOAD = 4'(FRAME_GAP_CYC - 1);

  state_t state_reg, state_next;
  timer_t timer_reg, timer_next;
  bit_count_t bit_reg, bit_next;
  word_t tx_reg, tx_next;
  word_t sent_reg, sent_next;
  word_t rx_reg, rx_next;
  word_t rx_out_reg, rx_out_next;
  logic sclk_reg, sclk_next;
  logic frame_n_reg, frame_n_next;
  logic serial_in_reg, serial_in_next;
  logic rise_reg, rise_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic so_s1_reg, so_s2_reg, so_s3_reg, so_filt_reg, so_filt_next;

  assign link.ser_clk = sclk_reg;
  assign link.frame_n = frame_n_reg;
  assign link.serial_in = serial_in_reg;
  assign o_busy = busy_reg;
  assign o_done = done_reg;
  assign o_rx_word = rx_out_reg;
  assign o_rise_edge = rise_reg;

  // ****************************************************************
  // Returned data synchroniser
  // ****************************************************************
  assign so_filt_next = (so_s2_reg == so_s3_reg) ? so_s3_reg : so_filt_reg;

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      so_s1_reg <= 1'b0;
      so_s2_reg <= 1'b0;
      so_s3_reg <= 1'b0;
      so_filt_reg <= 1'b0;
    end
    else
    begin
      so_s1_reg <= link.serial_out;
      so_s2_reg <= so_s1_reg;
      so_s3_reg <= so_s2_reg;
      so_filt_reg <= so_filt_next;
    end
  end

  // ****************************************************************
  // Frame sequencer
  // ****************************************************************
  // The clock idles at the level before the capture edge, so each bit
  // is a lead half (data steady) followed by an active half.
  always_comb
  begin
    state_next = state_reg;
    timer_next = timer_reg;
    bit_next = bit_reg;
    tx_next = tx_reg;
    sent_next = sent_reg;
    rx_next = rx_reg;
    rx_out_next = rx_out_reg;
    sclk_next = sclk_reg;
    frame_n_next = frame_n_reg;
    serial_in_next = serial_in_reg;
    rise_next = rise_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (timer_reg != 4'h0)
    begin
      timer_next = timer_reg - 4'h1;
    end
    case (state_reg)
      ST_IDLE:
      begin
        sclk_next = ~rise_reg;
        if (i_start)
        begin
          tx_next = i_word;
          sent_next = i_word;
          serial_in_next = i_word[WORD_W-1];
          frame_n_next = 1'b0;
          busy_next = 1'b1;
          bit_next = '0;
          timer_next = HALF_LOAD;
          state_next = ST_LEAD;
        end
      end
      ST_LEAD:
      begin
        if (timer_reg == 4'h0)
        begin
          if (bit_reg != 5'h00)
          begin
            rx_next = {rx_reg[WORD_W-2:0], so_filt_reg};
          end
          if (bit_reg == BIT_DONE)
          begin
            frame_n_next = 1'b1;
            timer_next = GAP_LOAD;
            state_next = ST_GAP;
          end
          else
          begin
            sclk_next = rise_reg;
            timer_next = HALF_LOAD;
            state_next = ST_ACTIVE;
          end
        end
      end
      ST_ACTIVE:
      begin
        if (timer_reg == 4'h0)
        begin
          sclk_next = ~rise_reg;
          bit_next = bit_reg + 5'h01;
          tx_next = {tx_reg[WORD_W-2:0], 1'b0};
          serial_in_next = tx_reg[WORD_W-2];
          timer_next = HALF_LOAD;
          state_next = ST_LEAD;
        end
      end
      ST_GAP:
      begin
        if (timer_reg == 4'h0)
        begin
          rx_out_next = rx_reg;
          done_next = 1'b1;
          busy_next = 1'b0;
          // The idle level moves here, with the frame closed, so that the
          // next frame never opens on a stray clock edge.
          if (cmd_of(sent_reg) == CMD_EDGE_RISE)
          begin
            rise_next = 1'b1;
            sclk_next = 1'b0;
          end
          else if (cmd_of(sent_reg) == CMD_EDGE_FALL)
          begin
            rise_next = 1'b0;
            sclk_next = 1'b1;
          end
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_reg <= ST_IDLE;
      timer_reg <= '0;
      bit_reg <= '0;
      tx_reg <= '0;
      sent_reg <= '0;
      rx_reg <= '0;
      rx_out_reg <= '0;
      sclk_reg <= 1'b1;
      frame_n_reg <= 1'b1;
      serial_in_reg <= 1'b0;
      rise_reg <= MODE_RESET_RISE;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      bit_reg <= bit_next;
      tx_reg <= tx_next;
      sent_reg <= sent_next;
      rx_reg <= rx_next;
      rx_out_reg <= rx_out_next;
      sclk_reg <= sclk_next;
      frame_n_reg <= frame_n_next;
      serial_in_reg <= serial_in_next;
      rise_reg <= rise_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

endmodule // dac_serial_host
`default_nettype wire

// *** testbench/dac_link_props.sv ***
// Concurrent checks on the serial link wires and the host handshake.
`timescale 1ns/10ps
`default_nettype none
module dac_link_props
  import dac_link_pkg::*;
(
  // System
  input wire logic i_clk,
  input wire logic i_reset,
  // Link
  input wire logic ser_clk,
  input wire logic frame_n,
  input wire logic serial_in,
  // Host user side
  input wire logic [WORD_W-1:0] i_word,
  input wire logic o_busy,
  input wire logic o_done,
  input wire logic o_rise_edge
);
  logic prev_reg, prev_next, moved;
  logic [7:0] run_reg, run_next;
  logic [5:0] edges_reg, edges_next;

  // ****************************************************************
  // Helper counters
  // ****************************************************************
  // The run counter saturates so that a long idle never wraps into a short half period.
  assign moved = ser_clk != prev_reg;
  always_comb
  begin
    prev_next = ser_clk;
    run_next = moved ? 8'h01 : run_reg + {7'h00, run_reg != 8'hFF};
    edges_next = frame_n ? 6'h00 : edges_reg + {5'h00, moved};
    if (i_reset)
    begin
      prev_next = 1'b1;
      run_next = 8'h00;
      edges_next = 6'h00;
    end
  end
  always_ff @(posedge i_clk)
  begin
    prev_reg <= prev_next;
    run_reg <= run_next;
    edges_reg <= edges_next;
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  AST_IDLE_FRAME: assert property (!o_busy |-> frame_n)
    else $error("frame select low while host idle");
  AST_FRAME_START: assert property ($rose(o_busy) |-> $fell(frame_n))
    else $error("frame did not open with busy");
  AST_MSB_FIRST: assert property ($rose(o_busy) |-> serial_in == $past(i_word[WORD_W-1]))
    else $error("first data bit is not the word MSB");
  AST_EDGE_COUNT: assert property ($rose(frame_n) |-> edges_reg == 6'h20)
    else $error("frame did not carry sixteen clock periods");
  AST_DONE_AFTER: assert property ($rose(frame_n) |-> ##3 o_done)
    else $error("done not three cycles after frame end");
  AST_DONE_PULSE: assert property (o_done |-> !o_busy ##1 !o_done)
    else $error("done longer than one cycle");
  AST_BUSY_END: assert property ($fell(o_busy) |-> o_done)
    else $error("busy dropped without done");
  AST_SCLK_HALF: assert property (moved && !frame_n |-> run_reg >= 8'h08)
    else $error("link clock half period too short");
  AST_CAPTURE_HOLD: assert property (moved && !frame_n && ser_clk == o_rise_edge |->
    $stable(serial_in))
    else $error("data moved at the capture edge");
  AST_DATA_ON_OPPOSITE: assert property ($changed(serial_in) && !frame_n && $past(!frame_n)
    |-> moved && ser_clk != o_rise_edge)
    else $error("data changed off the opposite edge");
endmodule // dac_link_props
`default_nettype wire

// *** testbench/dac_serial_input_port_tb.sv ***
// Self-checking bench joining the host and device ends of the serial DAC link.
`timescale 1ns/10ps
`default_nettype none
module dac_serial_input_port_tb
  import dac_link_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic dev_reset = 1'b1;
  logic i_start = 1'b0;
  word_t i_word = 16'h0000;
  logic o_busy, o_done, o_rise_edge, dev_rise;
  word_t o_rx_word;
  code_t o_dac_code;
  int mismatches = 0;
  int compares = 0;
  int seed = 32'h2F27;
  word_t shreg_m = 16'h0000;
  code_t code_m = 12'h000;
  logic rise_m = 1'b0;

  always #(CLK_PERIOD_NS / 2) i_clk = ~i_clk;

  dac_link_if link_if ();
  dac_serial_host dac_serial_host_inst (.i_clk(i_clk), .i_reset(i_reset), .link(link_if),
    .i_start(i_start), .i_word(i_word), .o_busy(o_busy), .o_done(o_done),
    .o_rx_word(o_rx_word), .o_rise_edge(o_rise_edge));
  dac_serial_dev dac_serial_dev_inst (.link(link_if), .i_reset(dev_reset),
    .o_dac_code(o_dac_code), .o_rise_edge(dev_rise));
  dac_link_props dac_link_props_inst (.i_clk(i_clk), .i_reset(i_reset),
    .ser_clk(link_if.ser_clk), .frame_n(link_if.frame_n), .serial_in(link_if.serial_in),
    .i_word(i_word), .o_busy(o_busy), .o_done(o_done), .o_rise_edge(o_rise_edge));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input word_t exp, input word_t got);
    compares++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A second start is pulsed mid-frame with a different word; the host must ignore it.
  task automatic send(input word_t w, input logic chk);
    int n;
    n = 0;
    i_start = 1'b1;
    i_word = w;
    @(negedge i_clk);
    i_start = 1'b0;
    while (o_done !== 1'b1 && n < 400)
    begin
      @(negedge i_clk);
      n++;
      if (n == 100)
      begin
        i_start = 1'b1;
        i_word = ~w;
      end
      else if (n == 101)
        i_start = 1'b0;
    end
    check("latency", 16'(WORD_W * 2 * SCLK_HALF_CYC + SCLK_HALF_CYC + FRAME_GAP_CYC), 16'(n));
    if (chk)
    begin
      check("rx word", shreg_m, o_rx_word);
      case (w[15:12])
        CMD_LOAD: code_m = w[11:0];
        CMD_EDGE_RISE: rise_m = 1'b1;
        CMD_EDGE_FALL: rise_m = 1'b0;
        default: ;
      endcase
      shreg_m = (w[15:12] == CMD_READBACK) ? {CMD_READBACK, code_m} : w;
      check("dac code", {4'h0, code_m}, {4'h0, o_dac_code});
      check("dev edge", {15'h0000, rise_m}, {15'h0000, dev_rise});
      check("host edge", {15'h0000, rise_m}, {15'h0000, o_rise_edge});
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    word_t corner [12] = '{16'h1FFF, 16'h2000, 16'h0ABC, 16'h1000, 16'h9123, 16'h1A5A,
      16'h2000, 16'h0000, 16'h5FFF, 16'hA000, 16'h3777, 16'h1800};
    repeat (20) @(negedge i_clk);
    i_reset = 1'b0;
    check("idle frame", 16'h0001, {15'h0000, link_if.frame_n});
    check("idle clock", 16'h0001, {15'h0000, link_if.ser_clk});
    check("host flags", 16'h0000, {13'h0000, o_busy, o_done, o_rise_edge});
    check("rx reset", 16'h0000, o_rx_word);
    @(negedge i_clk);
    // The device only sees clock edges inside a frame, so its reset spans one frame.
    send(16'h0000, 1'b0);
    dev_reset = 1'b0;
    check("reset code", 16'h0000, {4'h0, o_dac_code});
    check("reset edge", 16'h0000, {15'h0000, dev_rise});
    for (int k = 0; k < 12; k++)
      send(corner[k], 1'b1);
    repeat (24)
      send(16'($random(seed)), 1'b1);
    wrap_up();
  end

  initial
  begin
    repeat (60 * 300) @(posedge i_clk);
    mismatches++;
    wrap_up();
  end
endmodule // dac_serial_input_port_tb
`default_nettype wire
